// ### cti_pkg.sv
package cti_pkg;

  // Datapath and buffer geometry
  localparam int DATA_W    = 8;
  localparam int WORD_W    = 2 * DATA_W;
  localparam int ADDR_W    = 5;
  localparam int MEM_DEPTH = 32;

  // Delay excursion and centre tap
  localparam int MAX_RANGE = 12;
  localparam int NOM_DLY   = 13;
  localparam int MARK_W    = NOM_DLY + MAX_RANGE;

  // Fixed latency of luma matched to the chroma path at nominal delay
  localparam int SPAN_LAT  = 8;
  localparam int LUMA_DLY  = SPAN_LAT + NOM_DLY + 2;

  // Activity to delay scaling at gain one
  localparam int GAIN_BASE_SHIFT = 3;

  // Range selections, in pixels
  localparam logic [4:0] RANGE_SEL0 = 5'h0c;
  localparam logic [4:0] RANGE_SEL1 = 5'h08;
  localparam logic [4:0] RANGE_SEL2 = 5'h06;
  localparam logic [4:0] RANGE_SEL3 = 5'h04;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;

  // Control register fields
  localparam int CTRL_W         = 7;
  localparam int CTRL_RANGE_LSB = 0;
  localparam int CTRL_GAIN_LSB  = 2;
  localparam int CTRL_OHP_BIT   = 4;
  localparam int CTRL_BIN_BIT   = 5;
  localparam int CTRL_WIDTH_BIT = 6;
  localparam logic [6:0] CTRL_RESET = 7'h40;

  // Status register fields
  localparam int CFG_W          = 5;
  localparam int STAT_CFG_LSB   = 0;
  localparam int STAT_DELTA_LSB = 8;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } cti_bus_state_type;

endpackage

// ### cti_mem_if.sv
interface cti_mem_if;
  logic                       we;
  logic [cti_pkg::ADDR_W-1:0] waddr;
  logic [cti_pkg::ADDR_W-1:0] raddr;
  logic [cti_pkg::WORD_W-1:0] wdata;
  logic [cti_pkg::WORD_W-1:0] rdata;

  modport ctrl (output we, output waddr, output raddr, output wdata,
                input rdata);
  modport mem (input we, input waddr, input raddr, input wdata,
               output rdata);
endinterface

// ### cti_delay_mem.sv
module cti_delay_mem (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  cti_mem_if.mem   port_if
);
  logic [cti_pkg::WORD_W-1:0] mem_ff [cti_pkg::MEM_DEPTH];
  logic [cti_pkg::WORD_W-1:0] rdata_ff;

  // Storage, no reset
  always_ff @(posedge sys_clk) begin
    if (clk_en && port_if.we) begin
      mem_ff[port_if.waddr] <= port_if.wdata;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (clk_en) begin
      rdata_ff <= mem_ff[port_if.raddr];
    end
  end

  assign port_if.rdata = rdata_ff;
endmodule

// ### cti_transient_improver.sv
// Behaviour
// - Linear 2:1 interpolation turns 4:1:1 chroma into 4:2:2 chroma.
// - Second stage delay follows derivative of summed absolute U,V slopes.
// - Delay above nominal in first edge half, below in second half.
// - Second stage runs at luma sample rate, giving 4:4:4 chroma.
// - Zero gain gives plain 2:1 interpolation, no delay modulation.
// - Delay excursion selectable as 12, 8, 6 or 4 pixels either way.
// - Gain selectable as zero, one quarter, one half or one.
// - Protection marks slope sign changes; delay never reaches past them.
// - Nibble chroma bus assembled into sequential 8-bit U and V words.
// - Two bits select binary or two's complement and 8 or 7 bits.
module cti_transient_improver (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  chroma_in_bus,
  input  wire logic [7:0]  luma_in_bus,
  input  wire logic        line_start,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [7:0]  luma_out,
  output logic      [7:0]  u_out,
  output logic      [7:0]  v_out
);
  localparam int PIN_W = 13;

  // Two's complement conversion and 7-bit truncation
  function automatic logic [7:0] conv_code(logic [7:0] x, logic bin_sel,
                                           logic w8_sel);
    logic [7:0] y;
    y = bin_sel ? (x ^ 8'h80) : x;
    conv_code = w8_sel ? y : (y & 8'hfe);
  endfunction

  // Pixel-rate sample between two 4:1:1 samples at a given phase
  function automatic logic [7:0] interp(logic [7:0] p, logic [7:0] c,
                                        logic [1:0] ph);
    logic signed [9:0] sp;
    logic signed [9:0] sc;
    logic signed [9:0] sum;
    sp = signed'({{2{p[7]}}, p});
    sc = signed'({{2{c[7]}}, c});
    case (ph)
      2'h0: sum = sp + sp + sp + sp;
      2'h1: sum = sp + sp + sp + sc;
      2'h2: sum = sp + sp + sc + sc;
      default: sum = sp + sc + sc + sc;
    endcase
    interp = sum[9:2];
  endfunction

  function automatic logic [4:0] range_limit(logic [1:0] sel);
    logic [4:0] r;
    case (sel)
      2'h0: r = cti_pkg::RANGE_SEL0;
      2'h1: r = cti_pkg::RANGE_SEL1;
      2'h2: r = cti_pkg::RANGE_SEL2;
      default: r = cti_pkg::RANGE_SEL3;
    endcase
    range_limit = r;
  endfunction

  // Distance from centre to nearest slope sign change, older or newer side
  function automatic logic [4:0] mark_dist(
    logic [cti_pkg::MARK_W-1:0] mk, logic older);
    logic [4:0] d;
    d = 5'(cti_pkg::MAX_RANGE);
    for (int i = cti_pkg::MAX_RANGE; i >= 1; i--) begin
      if (older && mk[cti_pkg::NOM_DLY - 1 + i]) begin
        d = 5'(i);
      end else if (!older && mk[cti_pkg::NOM_DLY - 1 - i]) begin
        d = 5'(i);
      end
    end
    mark_dist = d;
  endfunction

  function automatic logic addr_is(logic [3:0] addr, logic [3:0] off);
    addr_is = (addr == off);
  endfunction

  cti_mem_if mem_if ();

  cti_delay_mem u_mem (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .port_if (mem_if)
  );

  logic [PIN_W-1:0]              pin_s1_ff;
  logic [PIN_W-1:0]              pin_s2_ff;
  logic                          line_prev_ff;
  logic                          line_edge;
  logic [cti_pkg::CTRL_W-1:0]    ctrl_ff;
  logic [cti_pkg::CFG_W-1:0]     cfg_ff;
  cti_pkg::cti_bus_state_type    bus_ff;
  logic                          waitreq_ff;
  logic [31:0]                   rdata_ff;
  logic [31:0]                   rd_mux;
  logic [1:0]                    ph_ff;
  logic [1:0]                    cur_ph;
  logic [7:0]                    u_hi_ff;
  logic [7:0]                    u_word_ff;
  logic [3:0]                    v_hi_ff;
  logic [7:0]                    prev_u_ff;
  logic [7:0]                    prev_v_ff;
  logic [7:0]                    cur_u_ff;
  logic [7:0]                    cur_v_ff;
  logic [7:0]                    wd_u_ff;
  logic [7:0]                    wd_v_ff;
  logic [7:0]                    old_u_ff;
  logic [7:0]                    old_v_ff;
  logic signed [8:0]             du;
  logic signed [8:0]             dv;
  logic [8:0]                    act;
  logic [8:0]                    act_ff;
  logic                          du_neg_ff;
  logic                          dv_neg_ff;
  logic signed [9:0]             s_pipe_ff [cti_pkg::NOM_DLY];
  logic [cti_pkg::MARK_W-1:0]    mk_ff;
  logic signed [9:0]             s_ctr;
  logic signed [9:0]             g_val;
  logic signed [9:0]             lim_pos;
  logic signed [9:0]             nxt_delta;
  logic signed [4:0]             delta_ff;
  logic [cti_pkg::ADDR_W-1:0]    wr_ptr_ff;
  logic                          primed_ff;
  logic [7:0]                    luma_pipe_ff [cti_pkg::LUMA_DLY];
  logic [7:0]                    luma_out_ff;
  logic [7:0]                    u_out_ff;
  logic [7:0]                    v_out_ff;

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else if (clk_en) begin
      pin_s1_ff <= {line_start, luma_in_bus, chroma_in_bus};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_prev_ff <= 1'b0;
    end else if (clk_en) begin
      line_prev_ff <= pin_s2_ff[12];
    end
  end

  assign line_edge = pin_s2_ff[12] && !line_prev_ff;

  // Avalon slave: one wait cycle, then answer
  always_comb begin
    rd_mux = 32'h0;
    if (addr_is(avs_address, cti_pkg::REG_CTRL)) begin
      rd_mux[cti_pkg::CTRL_W-1:0] = ctrl_ff;
    end else if (addr_is(avs_address, cti_pkg::REG_STATUS)) begin
      rd_mux[cti_pkg::STAT_CFG_LSB +: cti_pkg::CFG_W] = cfg_ff;
      rd_mux[cti_pkg::STAT_DELTA_LSB +: 5] = delta_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ff     <= cti_pkg::BUS_IDLE;
      waitreq_ff <= 1'b1;
      rdata_ff   <= 32'h0;
    end else if (clk_en) begin
      case (bus_ff)
        cti_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_ff     <= cti_pkg::BUS_ACK;
            waitreq_ff <= 1'b0;
            rdata_ff   <= avs_read ? rd_mux : 32'h0;
          end
        end
        default: begin
          bus_ff     <= cti_pkg::BUS_IDLE;
          waitreq_ff <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= cti_pkg::CTRL_RESET;
    end else if (clk_en && bus_ff == cti_pkg::BUS_ACK && avs_write &&
                 avs_byteenable[0] &&
                 addr_is(avs_address, cti_pkg::REG_CTRL)) begin
      ctrl_ff <= avs_writedata[cti_pkg::CTRL_W-1:0];
    end
  end

  // Range, gain and protection settings applied only at line start
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= cti_pkg::CTRL_RESET[cti_pkg::CFG_W-1:0];
    end else if (clk_en && line_edge) begin
      cfg_ff <= ctrl_ff[cti_pkg::CFG_W-1:0];
    end
  end

  // Nibble phase, restarted at line start
  assign cur_ph = line_edge ? 2'h0 : ph_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= 2'h0;
    end else if (clk_en) begin
      ph_ff <= cur_ph + 2'h1;
    end
  end

  // Assemble U and V words from four nibbles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      u_hi_ff   <= 8'h00;
      u_word_ff <= 8'h00;
      v_hi_ff   <= 4'h0;
      prev_u_ff <= 8'h00;
      prev_v_ff <= 8'h00;
      cur_u_ff  <= 8'h00;
      cur_v_ff  <= 8'h00;
    end else if (clk_en) begin
      case (cur_ph)
        2'h0: u_hi_ff <= {pin_s2_ff[3:0], 4'h0};
        2'h1: u_word_ff <= {u_hi_ff[7:4], pin_s2_ff[3:0]};
        2'h2: v_hi_ff <= pin_s2_ff[3:0];
        default: begin
          prev_u_ff <= cur_u_ff;
          prev_v_ff <= cur_v_ff;
          cur_u_ff  <= conv_code(u_word_ff, ctrl_ff[cti_pkg::CTRL_BIN_BIT],
                                 ctrl_ff[cti_pkg::CTRL_WIDTH_BIT]);
          cur_v_ff  <= conv_code({v_hi_ff, pin_s2_ff[3:0]},
                                 ctrl_ff[cti_pkg::CTRL_BIN_BIT],
                                 ctrl_ff[cti_pkg::CTRL_WIDTH_BIT]);
        end
      endcase
    end
  end

  // 4:2:2 midpoints and pixel-rate interpolation, one sample per clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_u_ff  <= 8'h00;
      wd_v_ff  <= 8'h00;
      old_u_ff <= 8'h00;
      old_v_ff <= 8'h00;
    end else if (clk_en) begin
      wd_u_ff  <= interp(prev_u_ff, cur_u_ff, cur_ph);
      wd_v_ff  <= interp(prev_v_ff, cur_v_ff, cur_ph);
      old_u_ff <= wd_u_ff;
      old_v_ff <= wd_v_ff;
    end
  end

  // Slope activity and its derivative
  always_comb begin
    du  = signed'({wd_u_ff[7], wd_u_ff}) - signed'({old_u_ff[7], old_u_ff});
    dv  = signed'({wd_v_ff[7], wd_v_ff}) - signed'({old_v_ff[7], old_v_ff});
    act = 9'(du[8] ? -du : du) + 9'(dv[8] ? -dv : dv);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_ff    <= 9'h000;
      du_neg_ff <= 1'b0;
      dv_neg_ff <= 1'b0;
      mk_ff     <= '0;
    end else if (clk_en) begin
      act_ff <= act;
      if (du != 9'sh000) begin
        du_neg_ff <= du[8];
      end
      if (dv != 9'sh000) begin
        dv_neg_ff <= dv[8];
      end
      mk_ff <= {mk_ff[cti_pkg::MARK_W-2:0],
                (du != 9'sh000 && du[8] != du_neg_ff) ||
                (dv != 9'sh000 && dv[8] != dv_neg_ff)};
    end
  end

  // Activity derivative carried to the centre tap
  generate
    for (genvar i = 0; i < cti_pkg::NOM_DLY; i++) begin : g_spipe
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s_pipe_ff[i] <= 10'sh000;
        end else if (clk_en) begin
          if (i == 0) begin
            s_pipe_ff[i] <= signed'({1'b0, act}) - signed'({1'b0, act_ff});
          end else begin
            s_pipe_ff[i] <= s_pipe_ff[(i > 0) ? i - 1 : 0];
          end
        end
      end
    end
  endgenerate

  // Delay offset: positive means older samples, i.e. longer delay
  always_comb begin
    s_ctr   = s_pipe_ff[cti_pkg::NOM_DLY-1];
    g_val   = s_ctr >>> (cti_pkg::GAIN_BASE_SHIFT + 3 -
                         int'(cfg_ff[cti_pkg::CTRL_GAIN_LSB +: 2]));
    lim_pos = signed'({5'h00,
                       range_limit(cfg_ff[cti_pkg::CTRL_RANGE_LSB +: 2])});
    nxt_delta = g_val;
    if (cfg_ff[cti_pkg::CTRL_GAIN_LSB +: 2] == 2'h0) begin
      nxt_delta = 10'sh000;
    end else if (g_val > lim_pos) begin
      nxt_delta = lim_pos;
    end else if (g_val < -lim_pos) begin
      nxt_delta = -lim_pos;
    end
    if (cfg_ff[cti_pkg::CTRL_OHP_BIT]) begin
      if (nxt_delta > signed'({5'h00, mark_dist(mk_ff, 1'b1)})) begin
        nxt_delta = signed'({5'h00, mark_dist(mk_ff, 1'b1)});
      end else if (nxt_delta < -signed'({5'h00, mark_dist(mk_ff, 1'b0)})) begin
        nxt_delta = -signed'({5'h00, mark_dist(mk_ff, 1'b0)});
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      delta_ff <= 5'sh00;
    end else if (clk_en) begin
      delta_ff <= nxt_delta[4:0];
    end
  end

  // Circular delay buffer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      primed_ff <= 1'b0;
    end else if (clk_en) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (wr_ptr_ff == 5'(cti_pkg::MEM_DEPTH - 1)) begin
        primed_ff <= 1'b1;
      end
    end
  end

  assign mem_if.we    = 1'b1;
  assign mem_if.waddr = wr_ptr_ff;
  assign mem_if.wdata = {wd_u_ff, wd_v_ff};
  assign mem_if.raddr = wr_ptr_ff - 5'(cti_pkg::NOM_DLY) - delta_ff;

  // Luma delay matching the chroma path
  generate
    for (genvar j = 0; j < cti_pkg::LUMA_DLY; j++) begin : g_lpipe
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          luma_pipe_ff[j] <= 8'h00;
        end else if (clk_en) begin
          luma_pipe_ff[j] <= (j == 0) ? pin_s2_ff[11:4] :
                             luma_pipe_ff[(j > 0) ? j - 1 : 0];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      luma_out_ff <= 8'h00;
      u_out_ff    <= 8'h00;
      v_out_ff    <= 8'h00;
    end else if (clk_en) begin
      luma_out_ff <= luma_pipe_ff[cti_pkg::LUMA_DLY-1];
      u_out_ff    <= primed_ff ? mem_if.rdata[15:8] : 8'h00;
      v_out_ff    <= primed_ff ? mem_if.rdata[7:0] : 8'h00;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign luma_out        = luma_out_ff;
  assign u_out           = u_out_ff;
  assign v_out           = v_out_ff;
endmodule

// ### cti_transient_improver_properties.sv
module cti_transient_improver_properties (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic [3:0]  chroma_in_bus,
  input wire logic [7:0]  luma_in_bus,
  input wire logic        line_start,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  luma_out,
  input wire logic [7:0]  u_out,
  input wire logic [7:0]  v_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  up_cnt_ff;
  logic [5:0]  flat_cnt_ff;
  logic [15:0] hist_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt_ff <= 6'h00;
    end else if (up_cnt_ff != 6'h3f) begin
      up_cnt_ff <= up_cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_ff <= 16'h0000;
    end else begin
      hist_ff <= {hist_ff[11:0], chroma_in_bus};
    end
  end

  // Counts cycles of a repeating nibble pattern with no register write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flat_cnt_ff <= 6'h00;
    end else if (avs_write || chroma_in_bus != hist_ff[15:12]) begin
      flat_cnt_ff <= 6'h00;
    end else if (flat_cnt_ff != 6'h3f) begin
      flat_cnt_ff <= flat_cnt_ff + 6'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_ans_pulse: assert property (
    !avs_waitrequest && clk_en |=> avs_waitrequest)
    else $error("answer held over one cycle");
  chk_ans_delay: assert property (
    (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
    else $error("answer not one cycle after request");
  chk_no_spurious: assert property (
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  chk_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && avs_address != cti_pkg::REG_CTRL &&
    avs_address != cti_pkg::REG_STATUS |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_high: assert property (
    avs_read && !avs_waitrequest && avs_address == cti_pkg::REG_CTRL
    |-> avs_readdata[31:7] == 25'h0)
    else $error("control upper bits not zero");
  chk_delta_bound: assert property (
    avs_read && !avs_waitrequest && avs_address == cti_pkg::REG_STATUS
    |-> avs_readdata[31:13] == 19'h0 && avs_readdata[7:5] == 3'h0 &&
    $signed(avs_readdata[12:8]) >= -12 && $signed(avs_readdata[12:8]) <= 12)
    else $error("delay offset out of range");
  chk_luma_delay: assert property (
    up_cnt_ff == 6'h3f |-> luma_out == $past(luma_in_bus, 26))
    else $error("luma latency wrong");
  chk_out_primed: assert property (
    up_cnt_ff < 6'h20 |-> u_out == 8'h00 && v_out == 8'h00)
    else $error("chroma out before buffer primed");
  chk_flat_hold: assert property (
    flat_cnt_ff == 6'h3f |-> $stable(u_out) && $stable(v_out))
    else $error("chroma out moved on flat input");
endmodule

// ### cti_adc_model.sv
module cti_adc_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] u_val,
  input  wire logic [7:0] v_val,
  output logic            line_start,
  output logic      [3:0] chroma_in_bus,
  output logic      [7:0] luma_in_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pix_ff;
  logic [7:0] u_ff;
  logic [7:0] v_ff;

  // Lines of 64 pixels; a sample is latched whole before its first nibble
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_ff <= 6'h00;
      u_ff <= 8'h00;
      v_ff <= 8'h00;
    end else begin
      pix_ff <= pix_ff + 6'h01;
      if (pix_ff[1:0] == 2'h3) begin
        u_ff <= u_val;
        v_ff <= v_val;
      end
    end
  end

  assign line_start = (pix_ff[5:2] == 4'h0);
  assign luma_in_bus = {pix_ff[1:0], pix_ff};
  // Nibble order: U high, U low, V high, V low
  always_comb begin
    case (pix_ff[1:0])
      2'h0: chroma_in_bus = u_ff[7:4];
      2'h1: chroma_in_bus = u_ff[3:0];
      2'h2: chroma_in_bus = v_ff[7:4];
      default: chroma_in_bus = v_ff[3:0];
    endcase
  end
endmodule

// ### cti_transient_improver_tb_top.sv
module cti_transient_improver_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk;
  logic              rst_n;
  logic              clk_en;
  logic              line_start;
  logic [3:0]        chroma_in_bus;
  logic [3:0]        avs_address;
  logic [3:0]        avs_byteenable;
  logic [7:0]        luma_in_bus;
  logic [7:0]        u_val;
  logic [7:0]        v_val;
  logic [7:0]        luma_out;
  logic [7:0]        u_out;
  logic [7:0]        v_out;
  logic              avs_read;
  logic              avs_write;
  logic              avs_waitrequest;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic [31:0]       rd;
  logic [4:0]        prev;
  logic signed [4:0] mx;
  logic signed [4:0] mn;
  int                num_errors;
  int                check_count;
  int                cyc;

  cti_adc_model u_adc (.sys_clk(sys_clk), .rst_n(rst_n), .u_val(u_val),
    .v_val(v_val), .line_start(line_start), .chroma_in_bus(chroma_in_bus),
    .luma_in_bus(luma_in_bus));

  cti_transient_improver u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .chroma_in_bus(chroma_in_bus),
    .luma_in_bus(luma_in_bus), .line_start(line_start),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .luma_out(luma_out), .u_out(u_out), .v_out(v_out));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One register access; the request is held until waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    // Only the watchdog ends a wait that never sees the answer
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_line();
    @(posedge line_start);
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic chroma_is(input logic [15:0] exp);
    repeat (80) @(posedge sys_clk);
    check({16'h0, u_out, v_out}, {16'h0, exp});
  endtask

  // Toggles U across a wide step every 75 cycles; reads every 3 cycles
  // drift against the one-cycle offset pulses, so pulses of both signs are caught on some steps
  task automatic probe(input logic [6:0] c);
    bus(1'b1, cti_pkg::REG_CTRL, {25'h0, c}, 4'hf);
    wait_line();
    wait_line();
    u_val <= 8'h90;
    repeat (80) @(posedge sys_clk);
    mx = 5'sd0;
    mn = 5'sd0;
    for (int k = 0; k < 200; k++) begin
      if (k % 25 == 0) begin
        u_val <= u_val ^ 8'he0;
      end
      bus(1'b0, cti_pkg::REG_STATUS, 32'h0, 4'hf);
      if ($signed(rd[12:8]) > mx) mx = rd[12:8];
      if ($signed(rd[12:8]) < mn) mn = rd[12:8];
    end
  endtask

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    u_val = 8'h35;
    v_val = 8'hca;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, cti_pkg::REG_CTRL, 32'h0, 4'hf);
    check(rd, 32'(cti_pkg::CTRL_RESET));
    chroma_is(16'h35ca);
    bus(1'b1, cti_pkg::REG_CTRL, 32'h60, 4'hf);
    chroma_is(16'hb54a);
    bus(1'b1, cti_pkg::REG_CTRL, 32'h20, 4'hf);
    chroma_is(16'hb44a);
    bus(1'b1, cti_pkg::REG_CTRL, 32'h00, 4'he);
    bus(1'b0, cti_pkg::REG_CTRL, 32'h0, 4'hf);
    check(rd, 32'h20);
    bus(1'b1, 4'h8, 32'hff, 4'hf);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    check(rd, 32'h0);
    bus(1'b1, cti_pkg::REG_STATUS, 32'h1f, 4'hf);
    bus(1'b0, cti_pkg::REG_STATUS, 32'h0, 4'hf);
    check({27'h0, rd[4:0]}, 32'h0);
    prev = 5'h00;
    for (int i = 0; i < 32; i++) begin
      wait_line();
      bus(1'b1, cti_pkg::REG_CTRL, 32'h40 | i, 4'hf);
      bus(1'b0, cti_pkg::REG_STATUS, 32'h0, 4'hf);
      check({27'h0, rd[4:0]}, {27'h0, prev});
      wait_line();
      bus(1'b0, cti_pkg::REG_STATUS, 32'h0, 4'hf);
      check({27'h0, rd[4:0]}, 32'(i));
      prev = 5'(i);
    end
    probe(7'h43);
    check({22'h0, mx, mn}, 32'h0);
    probe(7'h4f);
    check({27'h0, mx}, 32'h04);
    check({27'h0, mn}, 32'h1c);
    end_of_test();
  end
endmodule

bind cti_transient_improver cti_transient_improver_properties u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .chroma_in_bus(chroma_in_bus), .luma_in_bus(luma_in_bus),
  .line_start(line_start), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .luma_out(luma_out), .u_out(u_out), .v_out(v_out));
